// ==== smp_pkg.sv ====
package smp_pkg;
  // Register word byte addresses on the Wishbone bus
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CSR = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  // Control register fields
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_PORT_EN = 6;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_CPOL = 3;
  localparam int CTRL_CPHA = 2;
  localparam int CTRL_DIV_HI = 1;
  localparam int CTRL_DIV_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control-status register fields
  localparam int CSR_DONE = 7;
  localparam int CSR_WRITE_COLLISION_FLAG = 6;
  localparam int CSR_OVR = 5;
  localparam int CSR_MODE_FAULT_FLAG = 4;
  // Serial clock half-period reload counts, indexed by divider field; each half lasts count plus one system clocks
  localparam logic [7:0] HALF_DIV0 = 8'h01;
  localparam logic [7:0] HALF_DIV1 = 8'h02;
  localparam logic [7:0] HALF_DIV2 = 8'h04;
  localparam logic [7:0] HALF_DIV3 = 8'h08;
  localparam int BYTE_BITS = 8;
endpackage : smp_pkg

// ==== smp_sync.sv ====
`timescale 1ns/10ps
// Two-flop synchroniser for a group of pin levels
module smp_sync
  #(parameter int WIDTH = 3)
  (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
  );

  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : smp_sync

// ==== smp_spi.sv ====
`timescale 1ns/10ps
// Functional notes
// - Master: data write loads shift register, bits leave on MOSI MSB first
// - Done flag set at byte end; interrupt when enabled and CPU mask clear
// - Master: done clears by status access while set, then data read
// - Data writes ignored while done set until status register is accessed
// - Slave takes its serial clock from the SCK pin
// - Slave uses same polarity and phase as its master
// - Slave runs once master select cleared and port enable set
// - Slave: written byte shifts out MISO MSB first on master clock
// - Slave: done clears by status access while set, then data read or write
// - Master with select pin low sets mode fault and may interrupt
// - Mode fault clears port enable and master select
// - Mode fault clears by status read while set, then control write
// - While mode fault set, enable and master bits cannot be set
// - Slave never sets mode fault; an old one may stay set
// - Byte arriving while done still set raises overrun, may interrupt
// - After overrun the buffer keeps the first byte; later bytes dropped
// - Overrun clears on a status register read
// - Data write during a transfer is dropped and sets write collision
// - Write collision raises no interrupt
// - Received bytes go to a CPU-synchronous buffer
module smp_spi
  (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic cpu_irq_mask,
  output logic irq_req,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_b_i
  );

  typedef enum logic [1:0] {SMP_IDLE, SMP_LEAD, SMP_TRAIL} smp_state_e;

  logic [7:0] ctrl_reg;
  logic done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg;
  logic done_armed_reg, write_collision_flag_armed_reg, mode_fault_flag_armed_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_buf_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] div_cnt_reg;
  smp_state_e state_reg;
  logic sck_q_reg;
  logic sample_bit_reg;
  logic busy_reg;
  logic [2:0] pins_sync;
  logic sck_s, mosi_s, miso_s, ss_b_s;

  logic port_en, master, cpol, cpha;
  assign port_en = ctrl_reg[smp_pkg::CTRL_PORT_EN];
  assign master = ctrl_reg[smp_pkg::CTRL_MASTER];
  assign cpol = ctrl_reg[smp_pkg::CTRL_CPOL];
  assign cpha = ctrl_reg[smp_pkg::CTRL_CPHA];

  // Pin levels cross into the system clock before any logic reads them
  smp_sync #(.WIDTH(3)) u_sync
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in({sck_i, mosi_i, miso_i}),
    .sync_out(pins_sync)
  );
  assign sck_s = pins_sync[2];
  assign mosi_s = pins_sync[1];
  assign miso_s = pins_sync[0];

  // Select pin gets its own two-flop stage
  logic ss_meta_reg, ss_sync_reg;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ss_meta_reg <= 1'b1;
      ss_sync_reg <= 1'b1;
    end
    else
    begin
      ss_meta_reg <= ss_b_i;
      ss_sync_reg <= ss_meta_reg;
    end
  end
  assign ss_b_s = ss_sync_reg;

  // Bus decode; ack is one cycle and never back to back
  logic bus_req, wr_ctrl, wr_data, rd_csr, rd_data, acc_csr, hit;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  always_comb
  begin
    hit = 1'b1;
    if (wb_adr_i == smp_pkg::ADDR_CTRL)
      hit = 1'b1;
    else if (wb_adr_i == smp_pkg::ADDR_CSR)
      hit = 1'b1;
    else if (wb_adr_i == smp_pkg::ADDR_DATA)
      hit = 1'b1;
    else
      hit = 1'b0;
  end
  assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == smp_pkg::ADDR_CTRL;
  assign wr_data = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == smp_pkg::ADDR_DATA;
  assign rd_csr = bus_req && !wb_we_i && wb_adr_i == smp_pkg::ADDR_CSR;
  assign rd_data = bus_req && !wb_we_i && wb_adr_i == smp_pkg::ADDR_DATA;
  assign acc_csr = bus_req && wb_adr_i == smp_pkg::ADDR_CSR;

  // Master-side edge timing from the divider
  logic [7:0] half_cnt;
  always_comb
  begin
    case (ctrl_reg[smp_pkg::CTRL_DIV_HI:smp_pkg::CTRL_DIV_LO])
      2'b00: half_cnt = smp_pkg::HALF_DIV0;
      2'b01: half_cnt = smp_pkg::HALF_DIV1;
      2'b10: half_cnt = smp_pkg::HALF_DIV2;
      default: half_cnt = smp_pkg::HALF_DIV3;
    endcase
  end

  // Slave-side edges of the synchronised SCK; leading edge leaves the idle level
  logic slv_active, slv_lead, slv_trail, m_tick, lead_edge, trail_edge;
  assign slv_active = port_en && !master && !ss_b_s;
  assign slv_lead = slv_active && (sck_s != sck_q_reg) && (sck_q_reg == cpol);
  assign slv_trail = slv_active && (sck_s != sck_q_reg) && (sck_q_reg != cpol);
  assign m_tick = port_en && master && busy_reg && (div_cnt_reg == 8'h00);
  assign lead_edge = master ? (m_tick && state_reg != SMP_LEAD) : slv_lead;
  assign trail_edge = master ? (m_tick && state_reg == SMP_LEAD) : slv_trail;

  // Phase 0 samples on the leading edge, phase 1 on the trailing edge
  logic do_sample, do_shift, byte_end;
  assign do_sample = cpha ? trail_edge : lead_edge;
  assign do_shift = cpha ? lead_edge && bit_cnt_reg != 4'h0 : trail_edge;
  assign byte_end = trail_edge && bit_cnt_reg == 4'h7;

  // Write is accepted only when idle and the done flag is not pending
  logic wr_block, wr_take, wr_coll;
  assign wr_block = done_reg && !done_armed_reg;
  assign wr_coll = wr_data && busy_reg;
  assign wr_take = wr_data && !busy_reg && !wr_block;

  // Slave busy from first clock edge; select high resets it in either phase
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sck_q_reg <= 1'b0;
    else
      sck_q_reg <= sck_s;
  end

  // Transfer engine: shift register, bit counter and master clock generator
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      div_cnt_reg <= 8'h00;
      state_reg <= SMP_IDLE;
      sample_bit_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else if (!port_en || (!master && ss_b_s))
    begin
      // A dropped select aborts any half-shifted slave byte
      state_reg <= SMP_IDLE;
      bit_cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      if (wr_take)
        shift_reg <= wb_dat_i[7:0];
    end
    else
    begin
      if (wr_take)
      begin
        shift_reg <= wb_dat_i[7:0];
        busy_reg <= master;
        div_cnt_reg <= half_cnt;
      end
      else if (!master && lead_edge)
        busy_reg <= 1'b1;
      if (m_tick)
        div_cnt_reg <= half_cnt;
      else if (master && busy_reg && div_cnt_reg != 8'h00)
        div_cnt_reg <= div_cnt_reg - 8'h01;
      if (lead_edge)
        state_reg <= SMP_LEAD;
      if (do_sample)
        sample_bit_reg <= master ? miso_s : mosi_s;
      if (do_shift)
        shift_reg <= {shift_reg[6:0], sample_bit_reg};
      if (trail_edge)
      begin
        state_reg <= SMP_TRAIL;
        bit_cnt_reg <= byte_end ? 4'h0 : bit_cnt_reg + 4'h1;
      end
      if (byte_end)
      begin
        // Last bit lands here so the shift register holds the full byte
        if (cpha)
          shift_reg <= {shift_reg[6:0], (master ? miso_s : mosi_s)};
        state_reg <= SMP_IDLE;
        busy_reg <= 1'b0;
      end
    end
  end

  // Full received byte; at byte end the last bit has not reached the shift register yet
  logic [7:0] rx_byte;
  assign rx_byte = {shift_reg[6:0], (cpha ? (master ? miso_s : mosi_s) : sample_bit_reg)};

  // Receive buffer holds the first byte after a clear; later ones are lost
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rx_buf_reg <= 8'h00;
    else if (byte_end && !done_reg)
      rx_buf_reg <= rx_byte;
  end

  // Done flag: set wins over the clear sequence
  logic done_clr;
  assign done_clr = done_armed_reg && (rd_data || (wr_data && !master));
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done_reg <= 1'b0;
      done_armed_reg <= 1'b0;
    end
    else
    begin
      if (byte_end)
        done_reg <= 1'b1;
      else if (done_clr)
        done_reg <= 1'b0;
      if (byte_end || done_clr)
        done_armed_reg <= 1'b0;
      else if (acc_csr && done_reg)
        done_armed_reg <= 1'b1;
    end
  end

  // Overrun on a byte while done still set; status read clears it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ovr_reg <= 1'b0;
    else if (byte_end && done_reg)
      ovr_reg <= 1'b1;
    else if (rd_csr)
      ovr_reg <= 1'b0;
  end

  // Write collision: status only, cleared by status read then data read
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      write_collision_flag_reg <= 1'b0;
      write_collision_flag_armed_reg <= 1'b0;
    end
    else
    begin
      if (wr_coll)
        write_collision_flag_reg <= 1'b1;
      else if (write_collision_flag_armed_reg && rd_data)
        write_collision_flag_reg <= 1'b0;
      if (wr_coll || rd_data)
        write_collision_flag_armed_reg <= 1'b0;
      else if (rd_csr && write_collision_flag_reg)
        write_collision_flag_armed_reg <= 1'b1;
    end
  end

  // Mode fault only while master; the slave never raises it
  logic mode_fault_flag_event, mode_fault_flag_clr;
  assign mode_fault_flag_event = port_en && master && !ss_b_s;
  assign mode_fault_flag_clr = mode_fault_flag_armed_reg && wr_ctrl;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_fault_flag_reg <= 1'b0;
      mode_fault_flag_armed_reg <= 1'b0;
    end
    else
    begin
      if (mode_fault_flag_event)
        mode_fault_flag_reg <= 1'b1;
      else if (mode_fault_flag_clr)
        mode_fault_flag_reg <= 1'b0;
      if (mode_fault_flag_event || mode_fault_flag_clr)
        mode_fault_flag_armed_reg <= 1'b0;
      else if (rd_csr && mode_fault_flag_reg)
        mode_fault_flag_armed_reg <= 1'b1;
    end
  end

  // Control register; a fault drops enable and master and blocks their setting
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_reg <= smp_pkg::CTRL_RESET;
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_reg <= wb_dat_i[7:0];
        if (mode_fault_flag_reg && !mode_fault_flag_armed_reg)
        begin
          ctrl_reg[smp_pkg::CTRL_PORT_EN] <= 1'b0;
          ctrl_reg[smp_pkg::CTRL_MASTER] <= 1'b0;
        end
      end
      if (mode_fault_flag_event)
      begin
        ctrl_reg[smp_pkg::CTRL_PORT_EN] <= 1'b0;
        ctrl_reg[smp_pkg::CTRL_MASTER] <= 1'b0;
      end
    end
  end

  // Interrupt from done, fault or overrun; collision is left out on purpose
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_req <= 1'b0;
    else
      irq_req <= ctrl_reg[smp_pkg::CTRL_IRQ_EN] && !cpu_irq_mask
        && (done_reg || mode_fault_flag_reg || ovr_reg);
  end

  // Bus answer: ack one cycle after the request, err on unmapped words
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req && hit;
      wb_err_o <= bus_req && !hit;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i)
      begin
        if (wb_adr_i == smp_pkg::ADDR_CTRL)
          wb_dat_o[7:0] <= ctrl_reg;
        else if (wb_adr_i == smp_pkg::ADDR_CSR)
          wb_dat_o[7:0] <= {done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg, 4'h0};
        else if (wb_adr_i == smp_pkg::ADDR_DATA)
          wb_dat_o[7:0] <= rx_buf_reg;
      end
    end
  end

  // Pin drivers; nothing drives while the port is disabled
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      sck_oe <= port_en && master;
      mosi_oe <= port_en && master;
      miso_oe <= slv_active;
      sck_o <= (state_reg == SMP_LEAD) ? !cpol : cpol;
      mosi_o <= shift_reg[7];
      miso_o <= shift_reg[7];
    end
  end
endmodule : smp_spi

// ==== smp_spi_monitor.sv ====
`timescale 1ns/10ps
// Bus answer timing and pin ownership at the unit's ports
module smp_chk
  (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic cpu_irq_mask,
  input wire logic irq_req,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_b_i
  );
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Request still waiting for its answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  // Select pulled low while this unit drives the link
  sequence s_fault;
    sck_oe && !ss_b_i;
  endsequence
  a_bus_answer: assert property (s_req |=> wb_ack_o || wb_err_o)
    else $error("no bus answer");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_irq_masked: assert property (cpu_irq_mask |=> !irq_req)
    else $error("irq while masked");
  a_slave_clock_in: assert property (miso_oe |-> !sck_oe && !mosi_oe)
    else $error("slave drives clock");
  a_fault_release: assert property (s_fault |-> ##[1:6] !sck_oe)
    else $error("fault kept outputs");
  a_slave_idle: assert property (ss_b_i [*5] |-> !miso_oe)
    else $error("miso driven unselected");
  a_half_bit: assert property (sck_oe && $changed(sck_o) |=> $stable(sck_o))
    else $error("sck half period short");
  a_pin_pair: assert property (sck_oe == mosi_oe)
    else $error("enables differ");
endmodule : smp_chk

bind smp_spi smp_chk u_chk
  (
  .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .cpu_irq_mask(cpu_irq_mask),
  .irq_req(irq_req), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .ss_b_i(ss_b_i)
  );

// ==== smp_partner.sv ====
`timescale 1ns/10ps
// Link slave model: one byte per select
module smp_partner
  (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_b,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
  );
  logic sel_q = 1'b1;
  int m = 0;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  // Edge roles from phase; a released line shows the inverse, never the last bit
  always @(sck or sel_b)
  begin
    if (sel_b !== sel_q)
    begin
      sel_q = sel_b;
      m = cpha ? 0 : 1;
      miso = (!sel_b && !cpha) ? tx_byte[7] : ~miso;
    end
    else if (!sel_b && ((sck != cpol) != cpha))
      rx_byte = {rx_byte[6:0], mosi};
    else if (!sel_b && m < 8)
    begin
      miso = tx_byte[7 - m];
      m = m + 1;
    end
  end
endmodule : smp_partner

// ==== smp_spi_bench.sv ====
`timescale 1ns/10ps
// Bus master, link partner for master mode, link master for slave mode
module smp_spi_bench;
  localparam logic [3:0] A_CT = smp_pkg::ADDR_CTRL;
  localparam logic [3:0] A_CS = smp_pkg::ADDR_CSR;
  localparam logic [3:0] A_DT = smp_pkg::ADDR_DATA;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, v;
  logic wb_ack_o, wb_err_o, irq_req, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, e;
  logic cpu_irq_mask = 1'b0, ss_b = 1'b1, sck_m = 1'b0, mosi_m = 1'b0;
  logic psel_b = 1'b1, pol = 1'b0, pha = 1'b0, pmiso;
  logic [7:0] ptx = 8'h00;
  logic [7:0] prx, tx, got, b;
  int errors = 0, checked = 0;
  // Pin levels from whoever drives each line
  wire sck_ln = sck_oe ? sck_o : sck_m;
  wire mosi_ln = mosi_oe ? mosi_o : mosi_m;
  wire miso_ln = miso_oe ? miso_o : pmiso;
  // 10 MHz system clock
  initial forever #50 clk_sys = ~clk_sys;
  smp_spi dut
    (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .cpu_irq_mask(cpu_irq_mask), .irq_req(irq_req), .sck_i(sck_ln), .sck_o(sck_o),
    .sck_oe(sck_oe), .mosi_i(mosi_ln), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_ln), .miso_o(miso_o), .miso_oe(miso_oe), .ss_b_i(ss_b)
    );
  smp_partner u_partner
    (
    .sck(sck_ln), .mosi(mosi_ln), .sel_b(psel_b), .cpol(pol), .cpha(pha),
    .tx_byte(ptx), .miso(pmiso), .rx_byte(prx)
    );
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      errors++;
      give_verdict();
    end
  endtask : tmo
  // One classic cycle, held until the answer is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    tmo(n, 20);
    v = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic rdc(input logic [3:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h00);
    chk(v, {24'h0, x});
  endtask : rdc
  task automatic wait_irq();
    int n;
    for (n = 0; n < 3000 && irq_req !== 1'b1; n++)
      @(posedge clk_sys);
    tmo(n, 3000);
  endtask : wait_irq
  // Bench as link master at 800 ns, mode 0; select rises between bytes
  task automatic xfer(input logic [7:0] d);
    ss_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_m <= d[i];
      repeat (4) @(posedge clk_sys);
      sck_m <= 1'b1;
      // Slave output moves four clocks after the falling edge, so read it once settled
      @(posedge clk_sys);
      got[i] = miso_ln;
      repeat (3) @(posedge clk_sys);
      sck_m <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    ss_b <= 1'b1;
    mosi_m <= ~mosi_m;
  endtask : xfer
  // Main sequence: reset, master in all four modes, mode fault, slave
  initial
  begin
    void'($urandom(45210));
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(A_CT, 8'h00);
    rdc(A_CS, 8'h00);
    wb(1'b0, 4'hC, 8'h00);
    chk(e, 1'b1);
    for (int m = 0; m < 4; m++)
    begin
      pol <= m[1];
      pha <= m[0];
      tx = (m == 1) ? 8'h80 : 8'($urandom);
      ptx <= (m == 2) ? 8'h01 : 8'($urandom);
      wb(1'b1, A_CT, 8'hD3 | {4'h0, m[1:0], 2'b00});
      psel_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(sck_o, m[1]);
      wb(1'b1, A_DT, tx);
      wb(1'b1, A_DT, ~tx);
      wait_irq();
      chk(prx, tx);
      wb(1'b1, A_DT, 8'h3C);
      cpu_irq_mask <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(irq_req, 1'b0);
      cpu_irq_mask <= 1'b0;
      rdc(A_CS, 8'hC0);
      rdc(A_DT, ptx);
      psel_b <= 1'b1;
      repeat (300) @(posedge clk_sys);
      rdc(A_CS, 8'h00);
    end
    wb(1'b1, A_CT, 8'hD3);
    ss_b <= 1'b0;
    wait_irq();
    ss_b <= 1'b1;
    rdc(A_CT, 8'h83);
    wb(1'b1, A_CT, 8'hD3);
    rdc(A_CT, 8'h83);
    rdc(A_CS, 8'h10);
    wb(1'b1, A_CT, 8'h83);
    rdc(A_CS, 8'h00);
    wb(1'b1, A_CT, 8'hC0);
    tx = 8'($urandom);
    b = 8'($urandom);
    wb(1'b1, A_DT, tx);
    xfer(b);
    wait_irq();
    chk(got, tx);
    rdc(A_CS, 8'h80);
    xfer(~b);
    rdc(A_CS, 8'hA0);
    rdc(A_DT, b);
    rdc(A_CS, 8'h00);
    xfer(8'hFF);
    wait_irq();
    rdc(A_CS, 8'h80);
    wb(1'b1, A_DT, 8'h00);
    rdc(A_CS, 8'h00);
    give_verdict();
  end
endmodule : smp_spi_bench
